/* rtl/spc_pkg.sv */
package spc_pkg;
  localparam int SPC_ADDR_W = 10;
  localparam logic [9:0] SPC_OFF_PORT_CFG = 10'h000;
  localparam logic [9:0] SPC_OFF_SI_REV = 10'h002;
  localparam logic [9:0] SPC_OFF_VARIANT = 10'h003;
  localparam logic [9:0] SPC_OFF_RB_SEL = 10'h004;
  localparam logic [9:0] SPC_OFF_TAG_LO = 10'h005;
  localparam logic [9:0] SPC_OFF_TAG_HI = 10'h006;
  localparam int SPC_BIT_SEP_OUT = 7;
  localparam int SPC_BIT_LSB_FIRST = 6;
  localparam int SPC_BIT_SOFT_RST = 5;
  localparam logic [7:0] SPC_RST_PORT_CFG = 8'h00;
  localparam logic [7:0] SPC_RST_RB_SEL = 8'h00;
  localparam logic [7:0] SPC_RST_TAG = 8'h00;

  // read or write request from the serial framing logic
  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } spc_req_t;

  typedef struct packed {
    logic sep_out;
    logic lsb_first;
    logic soft_rst;
    logic rb_active;
    logic [15:0] tag;
    logic [7:0] rdata;
    logic soft_rst_pulse;
  } spc_state_t;
endpackage : spc_pkg

/* rtl/spc_regs.sv */
// Behaviour
// R01 - host writes bits 3:0 of port config as bit-reversed copy of 7:4
// R02 - writing one to port config bit 5 restores register defaults (here only readback select and tag, port config kept)
// R03 - soft reset bit self-clears on the clock after the write
// R04 - address 002 is read-only silicon revision, writes ignored
// R05 - address 003 is read-only variant identifier code
// R06 - bit 0 of 004 selects buffer (0) or active (1) readback
// R07 - addresses 005 and 006 hold low and high bytes of tag
// R08 - tag has no effect on behaviour, bytes reset to zero
// R09 - port config bit 6 selects lsb-first order in spi mode
// R10 - port config bit 7 selects separate output pin in spi mode
// R11 - in i2c mode unused port config bits read zero, writes ignored
`timescale 1ns/1ps
module spc_regs
  import spc_pkg::*;
#(
  parameter logic [7:0] SILICON_REV = 8'h01, // arbitrary value
  parameter logic [7:0] VARIANT_ID = 8'h5a // arbitrary value
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic i2c_mode,
  input wire spc_req_t req,
  output logic [7:0] rdata,
  output logic separate_output_select,
  output logic lsb_first,
  output logic readback_active,
  output logic soft_reset_pulse,
  output logic [15:0] customer_tag
);
  spc_state_t st_r;
  spc_state_t st_nxt;
  logic [7:4] cfg_upper;
  logic [3:0] cfg_mirror;
  logic [7:0] cfg_view;

  always_comb begin
    // unused bits read zero
    cfg_upper = 4'h0;
    if (!i2c_mode) begin // [R11]
      cfg_upper[SPC_BIT_SEP_OUT] = st_r.sep_out;
      cfg_upper[SPC_BIT_LSB_FIRST] = st_r.lsb_first;
    end
    cfg_upper[SPC_BIT_SOFT_RST] = st_r.soft_rst;
  end

  // mirror nibble is rebuilt from the upper nibble, whatever the host wrote there
  for (genvar gi = 0; gi < 4; gi++) begin : g_mirror
    assign cfg_mirror[gi] = cfg_upper[7 - gi]; // [R01]
  end

  assign cfg_view = {cfg_upper, cfg_mirror};

  always_comb begin
    st_nxt = st_r;
    st_nxt.soft_rst_pulse = 1'b0;
    st_nxt.soft_rst = 1'b0; // [R03]
    if (st_r.soft_rst) begin
      // defaults restored, port config itself kept
      st_nxt.rb_active = SPC_RST_RB_SEL[0]; // [R02]
      st_nxt.tag = {SPC_RST_TAG, SPC_RST_TAG}; // [R08]
    end
    if (req.wr) begin
      unique case (req.addr)
        SPC_OFF_PORT_CFG: begin
          if (!i2c_mode) begin // [R11]
            st_nxt.sep_out = req.wdata[SPC_BIT_SEP_OUT]; // [R10]
            st_nxt.lsb_first = req.wdata[SPC_BIT_LSB_FIRST]; // [R09]
          end
          st_nxt.soft_rst = req.wdata[SPC_BIT_SOFT_RST]; // [R02]
          st_nxt.soft_rst_pulse = req.wdata[SPC_BIT_SOFT_RST];
        end
        SPC_OFF_RB_SEL: st_nxt.rb_active = req.wdata[0]; // [R06]
        SPC_OFF_TAG_LO: st_nxt.tag[7:0] = req.wdata; // [R07]
        SPC_OFF_TAG_HI: st_nxt.tag[15:8] = req.wdata; // [R07]
        default: ; // read-only and unmapped addresses ignore writes [R04]
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        SPC_OFF_PORT_CFG: st_nxt.rdata = cfg_view;
        SPC_OFF_SI_REV: st_nxt.rdata = SILICON_REV; // [R04]
        SPC_OFF_VARIANT: st_nxt.rdata = VARIANT_ID; // [R05]
        SPC_OFF_RB_SEL: st_nxt.rdata = {7'h00, st_r.rb_active};
        SPC_OFF_TAG_LO: st_nxt.rdata = st_r.tag[7:0];
        SPC_OFF_TAG_HI: st_nxt.rdata = st_r.tag[15:8];
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.sep_out <= SPC_RST_PORT_CFG[SPC_BIT_SEP_OUT];
      st_r.lsb_first <= SPC_RST_PORT_CFG[SPC_BIT_LSB_FIRST];
      st_r.rb_active <= SPC_RST_RB_SEL[0];
      st_r.tag <= {SPC_RST_TAG, SPC_RST_TAG};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign separate_output_select = st_r.sep_out;
  assign lsb_first = st_r.lsb_first;
  assign readback_active = st_r.rb_active;
  assign soft_reset_pulse = st_r.soft_rst_pulse;
  assign customer_tag = st_r.tag;

  AST_SOFT_CLEAR: assert property (@(posedge clk) disable iff (srst) // [R03]
    st_r.soft_rst |=> !st_r.soft_rst || $past(req.wr))
    else $error("soft reset bit did not self-clear");
  AST_SOFT_DEFAULTS: assert property (@(posedge clk) disable iff (srst) // [R02]
    (st_r.soft_rst && !req.wr) |=> (customer_tag == 16'h0000 && !readback_active))
    else $error("soft reset did not restore defaults");
  AST_REV_READ: assert property (@(posedge clk) disable iff (srst) // [R04]
    (req.rd && req.addr == SPC_OFF_SI_REV) |=> rdata == SILICON_REV)
    else $error("silicon revision read wrong");
  AST_VARIANT_READ: assert property (@(posedge clk) disable iff (srst) // [R05]
    (req.rd && req.addr == SPC_OFF_VARIANT) |=> rdata == VARIANT_ID)
    else $error("variant identifier read wrong");
  AST_RB_SEL: assert property (@(posedge clk) disable iff (srst) // [R06]
    (req.wr && req.addr == SPC_OFF_RB_SEL && !st_r.soft_rst) |=> readback_active == $past(req.wdata[0]))
    else $error("readback select not stored");
  AST_TAG_HI: assert property (@(posedge clk) disable iff (srst) // [R07]
    (req.wr && req.addr == SPC_OFF_TAG_HI) |=> customer_tag[15:8] == $past(req.wdata))
    else $error("tag high byte not stored");
  AST_TAG_LO: assert property (@(posedge clk) disable iff (srst) // [R07]
    (req.wr && req.addr == SPC_OFF_TAG_LO) |=> customer_tag[7:0] == $past(req.wdata))
    else $error("tag low byte not stored");
  AST_ORDER: assert property (@(posedge clk) disable iff (srst) // [R09]
    (req.wr && req.addr == SPC_OFF_PORT_CFG && !i2c_mode) |=> lsb_first == $past(req.wdata[6]))
    else $error("bit order not stored");
  AST_SEP_OUT: assert property (@(posedge clk) disable iff (srst) // [R10]
    (req.wr && req.addr == SPC_OFF_PORT_CFG && !i2c_mode) |=> separate_output_select == $past(req.wdata[7]))
    else $error("pin scheme not stored");
  AST_I2C_ZERO: assert property (@(posedge clk) disable iff (srst) // [R11]
    (req.rd && req.addr == SPC_OFF_PORT_CFG && i2c_mode) |=> (rdata & 8'hdb) == 8'h00)
    else $error("unused bits not zero in i2c mode");
  AST_MIRROR: assert property (@(posedge clk) disable iff (srst) // [R01]
    (req.rd && req.addr == SPC_OFF_PORT_CFG) |=> rdata[3:0] == {rdata[4], rdata[5], rdata[6], rdata[7]})
    else $error("mirror nibble wrong");

  // outputs hold their reset values on the first edge after reset
  AST_RESET_TAG: assert property (@(posedge clk) disable iff (srst) // [R08]
    $fell(srst) |-> customer_tag == {SPC_RST_TAG, SPC_RST_TAG})
    else $error("tag not at reset value");
  AST_RESET_RB: assert property (@(posedge clk) disable iff (srst) // [R06]
    $fell(srst) |-> readback_active == SPC_RST_RB_SEL[0])
    else $error("readback select not at reset value");
  AST_RESET_ORDER: assert property (@(posedge clk) disable iff (srst) // [R09]
    $fell(srst) |-> lsb_first == SPC_RST_PORT_CFG[SPC_BIT_LSB_FIRST])
    else $error("bit order not at reset value");
  AST_RESET_SEP: assert property (@(posedge clk) disable iff (srst) // [R10]
    $fell(srst) |-> separate_output_select == SPC_RST_PORT_CFG[SPC_BIT_SEP_OUT])
    else $error("pin scheme not at reset value");

  // soft reset: one pulse per write, port config survives it
  AST_SOFT_SET: assert property (@(posedge clk) disable iff (srst) // [R02]
    (req.wr && req.addr == SPC_OFF_PORT_CFG && req.wdata[SPC_BIT_SOFT_RST])
    |=> (soft_reset_pulse && st_r.soft_rst))
    else $error("soft reset write not taken");
  AST_PULSE_ONE: assert property (@(posedge clk) disable iff (srst) // [R03]
    (soft_reset_pulse && !(req.wr && req.addr == SPC_OFF_PORT_CFG && req.wdata[SPC_BIT_SOFT_RST]))
    |=> !soft_reset_pulse)
    else $error("soft reset pulse longer than one cycle");
  AST_CFG_KEPT: assert property (@(posedge clk) disable iff (srst) // [R02]
    (st_r.soft_rst && !req.wr) |=> ($stable(separate_output_select) && $stable(lsb_first)))
    else $error("soft reset changed port config");
  AST_SOFT_READ: assert property (@(posedge clk) disable iff (srst) // [R03]
    (req.rd && req.addr == SPC_OFF_PORT_CFG) |=> rdata[SPC_BIT_SOFT_RST] == $past(st_r.soft_rst))
    else $error("soft reset bit read wrong");

  // read-only registers: a write leaves every stored field alone
  AST_REV_WRITE: assert property (@(posedge clk) disable iff (srst) // [R04]
    (req.wr && req.addr == SPC_OFF_SI_REV && !st_r.soft_rst)
    |=> ($stable(customer_tag) && $stable(readback_active) && $stable(separate_output_select) && $stable(lsb_first)))
    else $error("write to revision register changed state");
  AST_VARIANT_WRITE: assert property (@(posedge clk) disable iff (srst) // [R05]
    (req.wr && req.addr == SPC_OFF_VARIANT && !st_r.soft_rst)
    |=> ($stable(customer_tag) && $stable(readback_active) && $stable(separate_output_select) && $stable(lsb_first)))
    else $error("write to variant register changed state");

  // reads return the stored value from before the read
  AST_RB_READ: assert property (@(posedge clk) disable iff (srst) // [R06]
    (req.rd && req.addr == SPC_OFF_RB_SEL) |=> rdata == {7'h00, $past(readback_active)})
    else $error("readback select read wrong");
  AST_TAG_READ_LO: assert property (@(posedge clk) disable iff (srst) // [R07]
    (req.rd && req.addr == SPC_OFF_TAG_LO) |=> rdata == $past(customer_tag[7:0]))
    else $error("tag low byte read wrong");
  AST_TAG_READ_HI: assert property (@(posedge clk) disable iff (srst) // [R07]
    (req.rd && req.addr == SPC_OFF_TAG_HI) |=> rdata == $past(customer_tag[15:8]))
    else $error("tag high byte read wrong");
  AST_CFG_READ: assert property (@(posedge clk) disable iff (srst) // [R10]
    (req.rd && req.addr == SPC_OFF_PORT_CFG && !i2c_mode)
    |=> rdata[7:6] == {$past(separate_output_select), $past(lsb_first)})
    else $error("port config read wrong");

  // stored fields move only on a write or a soft reset
  AST_TAG_KEEP: assert property (@(posedge clk) disable iff (srst) // [R07]
    (!req.wr && !st_r.soft_rst) |=> $stable(customer_tag))
    else $error("tag changed without a write");
  AST_RB_KEEP: assert property (@(posedge clk) disable iff (srst) // [R06]
    (!req.wr && !st_r.soft_rst) |=> $stable(readback_active))
    else $error("readback select changed without a write");
  AST_CFG_IDLE: assert property (@(posedge clk) disable iff (srst) // [R09]
    !req.wr |=> ($stable(lsb_first) && $stable(separate_output_select)))
    else $error("port config changed without a write");
  AST_TAG_NO_EFFECT: assert property (@(posedge clk) disable iff (srst) // [R08]
    (req.wr && (req.addr == SPC_OFF_TAG_LO || req.addr == SPC_OFF_TAG_HI) && !st_r.soft_rst)
    |=> ($stable(readback_active) && $stable(separate_output_select) && $stable(lsb_first) && !soft_reset_pulse))
    else $error("tag write changed behaviour");
  AST_I2C_KEEP: assert property (@(posedge clk) disable iff (srst) // [R11]
    (req.wr && req.addr == SPC_OFF_PORT_CFG && i2c_mode)
    |=> ($stable(separate_output_select) && $stable(lsb_first)))
    else $error("i2c write changed spi-only bits");

  COV_SOFT: cover property (@(posedge clk) disable iff (srst) soft_reset_pulse ##1 !st_r.soft_rst);
  COV_TAG: cover property (@(posedge clk) disable iff (srst)
    (req.wr && req.addr == SPC_OFF_TAG_LO) ##1 (req.wr && req.addr == SPC_OFF_TAG_HI));
  COV_ACTIVE: cover property (@(posedge clk) disable iff (srst) $rose(readback_active));
  COV_I2C_WRITE: cover property (@(posedge clk) disable iff (srst)
    req.wr && req.addr == SPC_OFF_PORT_CFG && i2c_mode);
  COV_ID_READ: cover property (@(posedge clk) disable iff (srst)
    (req.rd && req.addr == SPC_OFF_SI_REV) ##2 (req.rd && req.addr == SPC_OFF_VARIANT));
endmodule : spc_regs

/* verification/spc_host.sv */
`timescale 1ns/1ps
module spc_host
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output spc_req_t req
);
  initial req = '0;
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    // low nibble of port config mirrors the high nibble bit-reversed
    req <= '{1'b1, 1'b0, a, (a == SPC_OFF_PORT_CFG) ? {d[7:4], d[4], d[5], d[6], d[7]} : d};
    @(posedge clk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask : rd
endmodule : spc_host

/* verification/test_serial_port_config_regs.sv */
`timescale 1ns/1ps
module test_serial_port_config_regs;
  import spc_pkg::*;
  logic clk = 0;
  logic srst = 1;
  logic i2c_mode = 0;
  spc_req_t req;
  logic [7:0] rdata, q;
  logic sep, lsb, rba, pls;
  logic [15:0] tag;
  int bad_count = 0;
  int checks = 0;
  // arbitrary identity values
  spc_regs #(.SILICON_REV(8'h3c), .VARIANT_ID(8'h7e)) u_spc_regs (.clk(clk), .srst(srst), .i2c_mode(i2c_mode),
    .req(req), .rdata(rdata), .separate_output_select(sep), .lsb_first(lsb), .readback_active(rba),
    .soft_reset_pulse(pls), .customer_tag(tag));
  spc_host u_spc_host (.clk(clk), .rdata(rdata), .req(req));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    u_spc_host.rd(a, q);
    chk({8'h00, q}, {8'h00, e});
  endtask : rd
  task automatic end_of_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic test_ids;
    rd(10'h002, 8'h3c);
    rd(10'h003, 8'h7e);
    u_spc_host.wr(10'h002, 8'hff);
    u_spc_host.wr(10'h003, 8'hff);
    rd(10'h002, 8'h3c);
    rd(10'h003, 8'h7e);
    rd(10'h004, 8'h00);
    rd(10'h005, 8'h00);
    rd(10'h006, 8'h00);
    $display("test_ids done");
  endtask : test_ids
  task automatic test_cfg;
    u_spc_host.wr(10'h000, 8'hc0);
    #1 chk(sep, 1'b1);
    chk(lsb, 1'b1);
    rd(10'h000, 8'hc3);
    @(posedge clk) i2c_mode <= 1'b1;
    u_spc_host.wr(10'h000, 8'h00);
    #1 chk(sep, 1'b1);
    chk(lsb, 1'b1);
    rd(10'h000, 8'h00);
    @(posedge clk) i2c_mode <= 1'b0;
    rd(10'h000, 8'hc3);
    $display("test_cfg done");
  endtask : test_cfg
  task automatic test_tag_reset;
    u_spc_host.wr(10'h004, 8'h01);
    u_spc_host.wr(10'h005, 8'h34);
    u_spc_host.wr(10'h006, 8'h12);
    #1 chk(tag, 16'h1234);
    chk(rba, 1'b1);
    rd(10'h005, 8'h34);
    u_spc_host.wr(10'h000, 8'h20);
    #1 chk(pls, 1'b1);
    @(posedge clk) #1 chk(pls, 1'b0);
    chk(tag, 16'h0000);
    chk(rba, 1'b0);
    chk(lsb, 1'b0);
    rd(10'h000, 8'h00);
    $display("test_tag_reset done");
  endtask : test_tag_reset
  initial begin
    #100000 bad_count++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    test_ids();
    test_cfg();
    test_tag_reset();
    end_of_test();
  end
endmodule : test_serial_port_config_regs
